// ### core/qudp_pulser.sv
// Quadrature encoder to select and up/down pulse sequencer
//
// Behaviour
// - Both phase inputs filtered and debounced internally
// - Debounce, find direction, then emit sequence
// - Write enable holds up/down high at deselect
// - Rate select high: four sequences per cycle
// - Rate select low: two sequences per cycle
// - Own power-on hold counter, started on release of the rst_b input
// - Pins undriven during power-on hold
// - Debounce about 5.5 ms, longer with noise
// - All timing from one master clock
// - Sequence edges spaced by 200 us
// - Up/down high for up, low for down
// - Decide from both phases' transition order
// - Ignore request while sequence still running
`timescale 1ns/1ps
module qudp_pulser #(
  parameter int unsigned POR_CYC   = qudp_pkg::POR_CYC,
  parameter int unsigned START_CYC = qudp_pkg::START_CYC,
  parameter int unsigned DEB_CYC   = qudp_pkg::DEB_CYC,
  parameter int unsigned STEP_CYC  = qudp_pkg::STEP_CYC
) (
  // Clock and power-on reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Encoder phases
  input  wire logic enc_a,
  input  wire logic enc_b,
  // Mode pins
  input  wire logic write_en,
  input  wire logic decode_rate_sel,
  // Potentiometer control, active-low select
  output logic      sel_n,
  output logic      sel_n_oe,
  output logic      updn,
  output logic      updn_oe
);

  localparam int unsigned PW = $clog2(POR_CYC + START_CYC + 1);
  localparam int unsigned SW = $clog2(STEP_CYC + 1);

  // Three-stage synchronisers for the four pins
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] sync_we;
  logic [2:0] sync_rate;
  logic       lvl_a;     // Accepted synchronised levels
  logic       lvl_b;
  logic       lvl_we;
  logic       lvl_rate;

  // Debounced phases and transition tracking
  logic       deb_a;
  logic       deb_b;
  logic [1:0] prev_ab;   // Last debounced state pair
  logic       armed;     // Startup delay has ended
  logic       por_done;  // Power-on hold has ended
  logic [PW-1:0] boot_cnt;

  // Sequencer
  qudp_pkg::qudp_state_e state;
  qudp_pkg::qudp_state_e next_state;
  logic [SW-1:0] step_cnt;
  logic          dir_up;   // Latched direction of the running sequence

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sync_a    <= 3'h7;
      sync_b    <= 3'h7;
      sync_we   <= 3'h0;
      sync_rate <= 3'h0;
    end
    else
    begin
      sync_a    <= {sync_a[1:0], enc_a};
      sync_b    <= {sync_b[1:0], enc_b};
      sync_we   <= {sync_we[1:0], write_en};
      sync_rate <= {sync_rate[1:0], decode_rate_sel};
    end
  end

  // change counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      lvl_a    <= 1'b1;
      lvl_b    <= 1'b1;
      lvl_we   <= 1'b0;
      lvl_rate <= 1'b0;
    end
    else
    begin
      if (sync_a[2] == sync_a[1])
        lvl_a <= sync_a[2];
      if (sync_b[2] == sync_b[1])
        lvl_b <= sync_b[2];
      if (sync_we[2] == sync_we[1])
        lvl_we <= sync_we[2];
      if (sync_rate[2] == sync_rate[1])
        lvl_rate <= sync_rate[2];
    end
  end

  qudp_debounce #(
    .DEB_CYC (DEB_CYC)
  ) u_deb_a (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .raw     (lvl_a),
    .clean   (deb_a)
  );

  qudp_debounce #(
    .DEB_CYC (DEB_CYC)
  ) u_deb_b (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .raw     (lvl_b),
    .clean   (deb_b)
  );

  // power-on hold then startup delay from one counter
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      boot_cnt <= '0;
      por_done <= 1'b0;
      armed    <= 1'b0;
    end
    else if (!armed)
    begin
      boot_cnt <= boot_cnt + 1'b1;
      if (boot_cnt == PW'(POR_CYC - 1))
        por_done <= 1'b1;
      if (boot_cnt == PW'(POR_CYC + START_CYC - 1))
        armed <= 1'b1;
    end
  end

  // direction from the ordered pair of both phases
  wire [1:0] cur_ab  = {deb_a, deb_b};
  wire [1:0] dir     = qudp_pkg::qudp_dir(prev_ab, cur_ab);
  wire       moved   = (dir != 2'h0);
  // half rate: only on transitions of phase A
  wire       a_edge  = (prev_ab[1] != cur_ab[1]);
  // full rate takes every valid transition
  wire       want    = moved && armed && (lvl_rate || a_edge);
  wire       idle    = (state == qudp_pkg::QUDP_IDLE);
  // a request during a running sequence is dropped
  wire       start   = want && idle;
  wire       step_end = (step_cnt == SW'(STEP_CYC - 1));

  // Track last debounced pair; always follows so no transition is replayed
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      prev_ab <= 2'h3;
    else
      prev_ab <= cur_ab;
  end

  // sequence starts only after debounce and direction
  always_comb
  begin
    next_state = state;
    case (state)
      qudp_pkg::QUDP_IDLE:  if (start)    next_state = qudp_pkg::QUDP_SETUP;
      qudp_pkg::QUDP_SETUP: if (step_end) next_state = qudp_pkg::QUDP_SEL;
      qudp_pkg::QUDP_SEL:   if (step_end) next_state = qudp_pkg::QUDP_COUNT;
      qudp_pkg::QUDP_COUNT: if (step_end) next_state = qudp_pkg::QUDP_HOLD;
      qudp_pkg::QUDP_HOLD:  if (step_end) next_state = qudp_pkg::QUDP_WRITE;
      qudp_pkg::QUDP_WRITE: if (step_end) next_state = qudp_pkg::QUDP_DONE;
      qudp_pkg::QUDP_DONE:  if (step_end) next_state = qudp_pkg::QUDP_IDLE;
      default:                            next_state = qudp_pkg::QUDP_IDLE;
    endcase
  end

  // each phase of the sequence lasts one interval
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state    <= qudp_pkg::QUDP_IDLE;
      step_cnt <= '0;
      dir_up   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      step_cnt <= (idle || step_end) ? '0 : step_cnt + 1'b1;
      if (start)
        dir_up <= (dir == 2'h1);
    end
  end

  // Output levels per state:
  // SETUP: up/down set to direction, select high
  // SEL: select falls, partner latches direction
  // COUNT: up/down low; HOLD: up/down rises, one count
  // WRITE: up/down per write enable, select rises
  // direction level at select fall
  // write enable forces high across deselect
  wire next_sel_n = !(state == qudp_pkg::QUDP_SEL || state == qudp_pkg::QUDP_COUNT ||
                      state == qudp_pkg::QUDP_HOLD);
  wire next_updn  = (state == qudp_pkg::QUDP_SETUP || state == qudp_pkg::QUDP_SEL) ? dir_up :
                    (state == qudp_pkg::QUDP_COUNT) ? 1'b0 :
                    (state == qudp_pkg::QUDP_HOLD)  ? 1'b1 :
                    (state == qudp_pkg::QUDP_WRITE) ? lvl_we :
                    qudp_pkg::RST_UPDN;

  // outputs undriven until the power-on hold ends
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sel_n    <= qudp_pkg::RST_SEL_N;
      updn     <= qudp_pkg::RST_UPDN;
      sel_n_oe <= 1'b0;
      updn_oe  <= 1'b0;
    end
    else
    begin
      sel_n    <= next_sel_n;
      updn     <= next_updn;
      sel_n_oe <= por_done;
      updn_oe  <= por_done;
    end
  end

endmodule : qudp_pulser

// ### shared/qudp_pkg.sv
// Package: timing constants, state encoding and helpers for the encoder pulser
package qudp_pkg;

  // Clock rate in kHz (40 MHz)
  localparam int unsigned CLK_KHZ          = 40000;

  // Power-on hold time, typical, in ms
  localparam int unsigned POR_MS           = 18;
  localparam int unsigned POR_CYC          = POR_MS * CLK_KHZ;

  // Startup delay after power-on hold, in ms
  localparam int unsigned START_MS         = 50;
  localparam int unsigned START_CYC        = START_MS * CLK_KHZ;

  // Debounce period, typical, in us (5.5 ms)
  localparam int unsigned DEB_US           = 5500;
  localparam int unsigned DEB_CYC          = DEB_US * CLK_KHZ / 1000;

  // Basic output interval in us
  localparam int unsigned STEP_US          = 200;
  localparam int unsigned STEP_CYC         = STEP_US * CLK_KHZ / 1000;

  // Filter integrator size and hysteresis thresholds
  localparam int unsigned FILT_MAX         = 255;
  localparam int unsigned FILT_HI          = 192;
  localparam int unsigned FILT_LO          = 63;

  // Values after reset
  localparam logic        RST_SEL_N        = 1'b1;
  localparam logic        RST_UPDN         = 1'b0;

  // Output sequencer states, Gray coded along the path from IDLE to DONE
  typedef enum logic [2:0] {
    QUDP_IDLE  = 3'b000,
    QUDP_SETUP = 3'b001,
    QUDP_SEL   = 3'b011,
    QUDP_COUNT = 3'b010,
    QUDP_HOLD  = 3'b110,
    QUDP_WRITE = 3'b111,
    QUDP_DONE  = 3'b101
  } qudp_state_e;

  // Quadrature direction: 1 up, 2 down, 0 none/invalid
  function automatic logic [1:0] qudp_dir(input logic [1:0] prev, input logic [1:0] cur);
    logic [3:0] idx;
    idx = {prev, cur};
    case (idx)
      // Up walk 11-01-00-10-11: phase A always changes before phase B
      4'h2, 4'hB, 4'hD, 4'h4: qudp_dir = 2'h1;  // A leads B, up
      4'h1, 4'h7, 4'hE, 4'h8: qudp_dir = 2'h2;  // B leads A, down
      default:                qudp_dir = 2'h0;
    endcase
  endfunction : qudp_dir

endpackage : qudp_pkg

// ### core/qudp_debounce.sv
// Debouncer: integrating filter, hysteresis and stability timer for one input
`timescale 1ns/1ps
module qudp_debounce #(
  parameter int unsigned DEB_CYC = qudp_pkg::DEB_CYC
) (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Synchronised raw level and debounced level
  input  wire logic raw,
  output logic      clean
);

  localparam int unsigned CW = $clog2(DEB_CYC + 1);
  // Filter tick divides half the debounce window across the integrator span
  localparam int unsigned TICK_CYC = (DEB_CYC / (2 * qudp_pkg::FILT_MAX)) > 0 ?
                                     (DEB_CYC / (2 * qudp_pkg::FILT_MAX)) : 1;
  localparam int unsigned TW = $clog2(TICK_CYC + 1);

  logic [TW-1:0] tick_cnt;  // Integrator rate divider
  logic [7:0]    acc;       // Running average of the input
  logic          cmp;       // Hysteresis comparator output
  logic [CW-1:0] stab;      // Stability timer

  wire tick    = (tick_cnt == TW'(TICK_CYC - 1));
  wire acc_top = (acc == 8'(qudp_pkg::FILT_MAX));
  wire acc_bot = (acc == 8'h00);
  // Noise keeps restarting the timer, so the period stretches with noise
  wire stab_end = (stab == CW'(DEB_CYC - 1));

  // Integrator: slow averaging removes short bounce pulses
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt <= '0;
      acc      <= 8'h80;
    end
    else
    begin
      tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
      if (tick && raw && !acc_top)
        acc <= acc + 8'h01;
      else if (tick && !raw && !acc_bot)
        acc <= acc - 8'h01;
    end
  end

  // Comparator with two levels gives hysteresis
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      cmp <= 1'b1;
    else if (acc >= 8'(qudp_pkg::FILT_HI))
      cmp <= 1'b1;
    else if (acc <= 8'(qudp_pkg::FILT_LO))
      cmp <= 1'b0;
  end

  // Timer: the comparator must hold still for the whole period
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stab  <= '0;
      clean <= 1'b1;
    end
    else if (cmp == clean)
      stab <= '0;
    else if (stab_end)
    begin
      stab  <= '0;
      clean <= cmp;
    end
    else
      stab <= stab + 1'b1;
  end

endmodule : qudp_debounce

// ### bench/qudp_checker.sv
// Checker: timing relations on the pulser outputs
`timescale 1ns/1ps
module qudp_checker #(
  parameter int unsigned POR_CYC   = 20,
  parameter int unsigned START_CYC = 20,
  parameter int unsigned STEP_CYC  = 4
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Mode input
  input wire logic write_en,
  // Outputs of the block
  input wire logic sel_n,
  input wire logic sel_n_oe,
  input wire logic updn,
  input wire logic updn_oe
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  logic [31:0] up_cnt;   // Cycles since release, saturating
  logic [7:0]  low_cnt;  // Cycles select held low
  logic [7:0]  high_cnt; // Cycles select held high, saturating
  logic [3:0]  rise_cnt; // Up/down rises while selected
  logic        updn_q;   // Up/down one cycle ago
  // Helper counters; saturation keeps long idle spans harmless
  always_ff @(posedge clk_sys or negedge rst_b)
    if (!rst_b)
    begin
      up_cnt   <= 32'h0;
      low_cnt  <= 8'h0;
      high_cnt <= 8'h0;
      rise_cnt <= 4'h0;
      updn_q   <= 1'b0;
    end
    else
    begin
      up_cnt   <= (up_cnt == 32'hFFFFF) ? up_cnt : up_cnt + 32'h1;
      low_cnt  <= sel_n ? 8'h0 : low_cnt + 8'h1;
      high_cnt <= !sel_n ? 8'h0 : ((high_cnt == 8'hFF) ? high_cnt : high_cnt + 8'h1);
      rise_cnt <= sel_n ? 4'h0 : rise_cnt + {3'h0, updn & ~updn_q};
      updn_q   <= updn;
    end
  property p_por_float;
    (up_cnt < POR_CYC) |-> !sel_n_oe && !updn_oe;
  endproperty
  a_por_float: assert property (p_por_float) else $error("pin driven in hold");
  property p_por_end;
    (up_cnt == POR_CYC + 4) |-> sel_n_oe && updn_oe;
  endproperty
  a_por_end: assert property (p_por_end) else $error("pins not driven");
  property p_oe_keep;
    sel_n_oe |=> sel_n_oe;
  endproperty
  a_oe_keep: assert property (p_oe_keep) else $error("drive dropped");
  property p_armed;
    (up_cnt < POR_CYC + START_CYC) |-> sel_n;
  endproperty
  a_armed: assert property (p_armed) else $error("select before startup");
  property p_sel_len;
    $rose(sel_n) |-> low_cnt == 3 * STEP_CYC;
  endproperty
  a_sel_len: assert property (p_sel_len) else $error("select low length");
  property p_one_step;
    $rose(sel_n) |-> rise_cnt == 4'h1;
  endproperty
  a_one_step: assert property (p_one_step) else $error("count edges wrong");
  property p_store;
    $rose(sel_n) |-> updn == $past(write_en, 8);
  endproperty
  a_store: assert property (p_store) else $error("store level wrong");
  property p_gap;
    $fell(sel_n) |-> high_cnt >= 3 * STEP_CYC;
  endproperty
  a_gap: assert property (p_gap) else $error("sequence overlap");
  property p_dir_hold;
    $fell(sel_n) |=> $stable(updn) [*3];
  endproperty
  a_dir_hold: assert property (p_dir_hold) else $error("direction moved");
  c_up: cover property ($fell(sel_n) ##0 updn);
  c_down: cover property ($fell(sel_n) ##0 !updn);
  c_store: cover property ($rose(sel_n) ##0 updn);
endmodule : qudp_checker

bind qudp_pulser qudp_checker #(
  .POR_CYC(POR_CYC), .START_CYC(START_CYC), .STEP_CYC(STEP_CYC)
) u_chk (
  .clk_sys(clk_sys), .rst_b(rst_b), .write_en(write_en), .sel_n(sel_n),
  .sel_n_oe(sel_n_oe), .updn(updn), .updn_oe(updn_oe)
);

// ### bench/qudp_pot_model.sv
// Model of the up/down digital potentiometer on the far side
`timescale 1ns/1ps
module qudp_pot_model (
  // Control lines as seen on the board
  input  wire logic sel_w,
  input  wire logic updn_w,
  // Wiper position and store count
  output int        wiper,
  output int        stores
);
  logic dir_up;  // Direction latched at select
  initial
  begin
    wiper  = 0;
    stores = 0;
    dir_up = 1'b0;
  end
  always @(negedge sel_w)
    dir_up = updn_w;
  always @(posedge updn_w)
    if (sel_w === 1'b0)
      wiper = dir_up ? wiper + 1 : wiper - 1;
  // store at deselect; sampled just after the edge, as a slow part would
  always @(posedge sel_w)
  begin
    #1;
    if (updn_w === 1'b1)
      stores = stores + 1;
  end
endmodule : qudp_pot_model

// ### bench/testbench.sv
// Testbench: encoder stimulus and scenario tasks for the pulser
`timescale 1ns/1ps
module testbench;
  logic clk_sys, rst_b, enc_a, enc_b, write_en, decode_rate_sel;
  logic sel_n, sel_n_oe, updn, updn_oe;
  wire  sel_w, updn_w;
  int   wiper, stores, fails, checks_done, c0, s0;
  // Board pull-up on select, pull-down on up/down while undriven
  assign sel_w  = sel_n_oe ? sel_n : 1'b1;
  assign updn_w = updn_oe ? updn : 1'b0;
  qudp_pulser #(.POR_CYC(20), .START_CYC(20), .DEB_CYC(600), .STEP_CYC(4)) u_dut (
    .clk_sys(clk_sys), .rst_b(rst_b), .enc_a(enc_a), .enc_b(enc_b),
    .write_en(write_en), .decode_rate_sel(decode_rate_sel),
    .sel_n(sel_n), .sel_n_oe(sel_n_oe), .updn(updn), .updn_oe(updn_oe)
  );
  qudp_pot_model u_pot (.sel_w(sel_w), .updn_w(updn_w), .wiper(wiper), .stores(stores));
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input int got, input int exp);
    checks_done++;
    if (got != exp)
    begin
      fails++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask : check
  // phase A moves first for up; B follows after gap
  task automatic step(input logic a, input logic b, input int gap);
    @(negedge clk_sys);
    enc_a = a;
    repeat (gap) @(negedge clk_sys);
    enc_b = b;
    repeat (1500) @(negedge clk_sys);
  endtask : step
  task automatic start(input logic rate, input logic we);
    decode_rate_sel = rate;
    write_en = we;
    c0 = wiper;
    s0 = stores;
  endtask : start
  task automatic t_up_full();
    start(1'b1, 1'b0);
    step(0, 1, 0);
    step(0, 0, 0);
    step(1, 0, 0);
    step(1, 1, 0);
    check(wiper - c0, 4);
    check(stores - s0, 0);
    $display("up full cycle done");
  endtask : t_up_full
  task automatic t_down_half();
    start(1'b0, 1'b0);
    step(1, 0, 0);
    step(0, 0, 0);
    step(0, 1, 0);
    step(1, 1, 0);
    check(wiper - c0, -2);
    $display("down half rate done");
  endtask : t_down_half
  task automatic t_write();
    start(1'b1, 1'b1);
    step(0, 1, 0);
    step(1, 1, 0);
    check(stores - s0, 2);
    check(wiper - c0, 0);
    $display("write store done");
  endtask : t_write
  task automatic t_bounce();
    start(1'b1, 1'b0);
    repeat (4)
    begin
      enc_a = 1'b0;
      repeat (15) @(negedge clk_sys);
      enc_a = 1'b1;
      repeat (15) @(negedge clk_sys);
    end
    step(0, 1, 0);
    step(0, 0, 0);
    step(1, 0, 0);
    step(1, 1, 0);
    check(wiper - c0, 4);
    $display("bounce done");
  endtask : t_bounce
  task automatic t_fast();
    start(1'b1, 1'b0);
    step(0, 0, 10);
    check(wiper - c0, 1);
    $display("fast pair done");
  endtask : t_fast
  task automatic end_sim();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_sim
  initial
  begin
    rst_b = 1'b0;
    enc_a = 1'b1;
    enc_b = 1'b1;
    write_en = 1'b0;
    decode_rate_sel = 1'b0;
    fails = 0;
    checks_done = 0;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (100) @(negedge clk_sys);
    t_up_full();
    t_down_half();
    t_write();
    t_bounce();
    t_fast();
    end_sim();
  end
  // Watchdog: tests need about 23000 cycles
  initial
  begin
    repeat (60000) @(posedge clk_sys);
    fails++;
    end_sim();
  end
endmodule : testbench
